// file: pusr_regs.svh
// timing constants and character codes for the power-up serial reporter
`ifndef PUSR_REGS_SVH
`define PUSR_REGS_SVH
`define PUSR_CLK_HZ          100000000
`define PUSR_BAUD            1200
`define PUSR_BIT_CYCLES      (`PUSR_CLK_HZ / `PUSR_BAUD)
`define PUSR_POWERUP_MAX_MS  100
`define PUSR_RISE_CYCLES     1000
`define PUSR_SETTLE_CYCLES   2000
`define PUSR_CHR_TAB         8'h09
`define PUSR_CHR_SPACE       8'h20
`define PUSR_CHR_CR          8'h0d
`define PUSR_CHR_LF          8'h0a
`define PUSR_CHR_DOT         8'h2e
`define PUSR_CHR_MINUS       8'h2d
`define PUSR_CHR_ZERO        8'h30
`define PUSR_CSUM_MOD_MASK   8'h3f
`define PUSR_CSUM_OFFSET     8'h20
`define PUSR_REC_LEN         24
`endif

// file: pusr_pkg.sv
// types shared by the power-up serial reporter modules
package pusr_pkg;
    typedef enum logic [4:0] {
        ST_MEASURE = 5'b00001,
        ST_SIGNAL  = 5'b00010,
        ST_BUILD   = 5'b00100,
        ST_SEND    = 5'b01000,
        ST_CMDMODE = 5'b10000
    } pusr_state_type;
    typedef enum logic [3:0] {
        TX_IDLE  = 4'b0001,
        TX_START = 4'b0010,
        TX_DATA  = 4'b0100,
        TX_STOP  = 4'b1000
    } pusr_tx_state_type;
endpackage : pusr_pkg

// file: pusr_tx_if.sv
// handshake between the report sequencer and the character serialiser
`timescale 1ns/1ps
interface pusr_tx_if;
    logic       load;
    logic [7:0] data;
    logic       busy;
    modport seq (output load, output data, input  busy);
    modport ser (input  load, input  data, output busy);
endinterface : pusr_tx_if

// file: pusr_tx.sv
// 8n1 active-high character serialiser
`timescale 1ns/1ps
`include "pusr_regs.svh"
module pusr_tx #(
    parameter int BIT_CYCLES = `PUSR_BIT_CYCLES
) (
    input  wire logic mclk_in,
    input  wire logic reset_n_in,
    pusr_tx_if.ser    tx,
    output logic      line_out
);
    pusr_pkg::pusr_tx_state_type st_reg, st_next;
    logic [16:0] cnt_reg, cnt_next;
    logic [2:0]  bit_reg, bit_next;
    logic [7:0]  sh_reg, sh_next;
    logic        line_reg, line_next;
    localparam logic [16:0] LAST = 17'(BIT_CYCLES - 1);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        bit_next = bit_reg;
        sh_next = sh_reg;
        line_next = line_reg;
        unique case (st_reg)
            pusr_pkg::TX_IDLE: begin
                line_next = 1'b1;                      // idle high
                if (tx.load) begin
                    sh_next = tx.data;
                    cnt_next = '0;
                    line_next = 1'b0;                  // start bit is low
                    st_next = pusr_pkg::TX_START;
                end
            end
            pusr_pkg::TX_START: begin
                cnt_next = cnt_reg + 17'h00001;
                if (cnt_reg == LAST) begin             // one bit time at 1200
                    cnt_next = '0;
                    bit_next = '0;
                    line_next = sh_reg[0];             // lsb first
                    st_next = pusr_pkg::TX_DATA;
                end
            end
            pusr_pkg::TX_DATA: begin
                cnt_next = cnt_reg + 17'h00001;
                if (cnt_reg == LAST) begin
                    cnt_next = '0;
                    if (bit_reg == 3'h7) begin
                        line_next = 1'b1;              // stop bit high, no parity
                        st_next = pusr_pkg::TX_STOP;
                    end else begin
                        bit_next = bit_reg + 3'h1;
                        sh_next = {1'b0, sh_reg[7:1]};
                        line_next = sh_reg[1];
                    end
                end
            end
            pusr_pkg::TX_STOP: begin
                cnt_next = cnt_reg + 17'h00001;
                if (cnt_reg == LAST) begin
                    cnt_next = '0;
                    st_next = pusr_pkg::TX_IDLE;
                end
            end
        endcase
    end

    // registers
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_reg <= pusr_pkg::TX_IDLE;
            cnt_reg <= '0;
            bit_reg <= '0;
            sh_reg <= '0;
            line_reg <= 1'b1;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            bit_reg <= bit_next;
            sh_reg <= sh_next;
            line_reg <= line_next;
        end
    end

    assign tx.busy = (st_reg != pusr_pkg::TX_IDLE) || tx.load;
    assign line_out = line_reg;
endmodule : pusr_tx

// file: pusr_reporter.sv
// power-up serial report sequencer, top level
`timescale 1ns/1ps
`include "pusr_regs.svh"
module pusr_reporter #(
    parameter int         BIT_CYCLES    = `PUSR_BIT_CYCLES,
    parameter int         RISE_CYCLES   = `PUSR_RISE_CYCLES,
    parameter int         SETTLE_CYCLES = `PUSR_SETTLE_CYCLES,
    parameter logic [7:0] TYPE_CHAR     = 8'h41   // arbitrary value
) (
    input  wire logic        mclk_in,
    input  wire logic        reset_n_in,
    input  wire logic        meas_done_in,
    input  wire logic [16:0] conductivity_value_in,
    input  wire logic [10:0] temp_tenths_in,
    input  wire logic        temp_neg_in,
    input  wire logic [7:0]  bus_addr_in,
    output logic             line_out,
    output logic             line_oe_n_out,
    output logic             cmd_mode_out
);
    // rise within 100 ms must be met by RISE_CYCLES
    localparam int MAX_RISE = `PUSR_POWERUP_MAX_MS * (`PUSR_CLK_HZ / 1000);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] digit_chr(input logic [3:0] d);
        digit_chr = `PUSR_CHR_ZERO + {4'h0, d};
    endfunction : digit_chr

    // ------------------------------------------------------------
    // input synchronisers (pins from the sensing front end)
    // ------------------------------------------------------------
    logic done_s1_reg, done_s2_reg;
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            done_s1_reg <= 1'b0;
            done_s2_reg <= 1'b0;
        end else begin
            done_s1_reg <= meas_done_in;
            done_s2_reg <= done_s1_reg;
        end
    end

    // ------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------
    pusr_pkg::pusr_state_type st_reg, st_next;
    logic [31:0] cnt_reg, cnt_next;
    logic [7:0]  rec_reg [`PUSR_REC_LEN], rec_next [`PUSR_REC_LEN];
    logic [4:0]  len_reg, len_next;
    logic [4:0]  idx_reg, idx_next;
    logic        hold_low_reg, hold_low_next;
    logic        cmd_reg, cmd_next;
    logic        load_reg, load_next;
    logic [7:0]  sum_reg, sum_next;
    logic        tx_line;
    pusr_tx_if   txi ();

    pusr_tx #(.BIT_CYCLES(BIT_CYCLES)) u_tx (
        .mclk_in    (mclk_in),
        .reset_n_in (reset_n_in),
        .tx         (txi.ser),
        .line_out   (tx_line)
    );
    assign txi.load = load_reg;
    assign txi.data = rec_reg[idx_reg];

    // record builder: fills characters and checksum in one pass
    always_comb begin
        logic [16:0] c;
        logic [10:0] t;
        logic [4:0]  n;
        logic [7:0]  s;
        logic [7:0]  ch [`PUSR_REC_LEN];
        logic        lead;
        c = conductivity_value_in;
        t = temp_tenths_in;
        n = '0;
        s = '0;
        lead = 1'b0;
        for (int i = 0; i < `PUSR_REC_LEN; i++) begin
            ch[i] = 8'h00;
        end
        ch[n] = `PUSR_CHR_TAB; n = n + 5'h1;
        // conductivity, leading zeros dropped
        for (int p = 4; p >= 0; p--) begin
            logic [3:0] d;
            d = 4'((c / (17'd1 * (10 ** p))) % 10);
            if (d != 4'h0 || lead || p == 0) begin
                lead = 1'b1;
                ch[n] = digit_chr(d);
                n = n + 5'h1;
            end
        end
        ch[n] = `PUSR_CHR_SPACE; n = n + 5'h1;
        if (temp_neg_in) begin
            ch[n] = `PUSR_CHR_MINUS; n = n + 5'h1;
        end
        lead = 1'b0;
        for (int p = 3; p >= 1; p--) begin
            logic [3:0] d;
            d = 4'((t / (11'd1 * (10 ** p))) % 10);
            if (d != 4'h0 || lead || p == 1) begin
                lead = 1'b1;
                ch[n] = digit_chr(d);
                n = n + 5'h1;
            end
        end
        ch[n] = `PUSR_CHR_DOT; n = n + 5'h1;           // one decimal digit
        ch[n] = digit_chr(4'(t % 11'd10)); n = n + 5'h1;
        ch[n] = `PUSR_CHR_CR; n = n + 5'h1;
        ch[n] = TYPE_CHAR; n = n + 5'h1;
        for (int i = 0; i < `PUSR_REC_LEN; i++) begin
            if (5'(i) < n) s = s + ch[i];              // covers tab to type
        end
        ch[n] = (s & `PUSR_CSUM_MOD_MASK) + `PUSR_CSUM_OFFSET;
        n = n + 5'h1;
        ch[n] = `PUSR_CHR_CR; n = n + 5'h1;
        ch[n] = `PUSR_CHR_LF; n = n + 5'h1;
        for (int i = 0; i < `PUSR_REC_LEN; i++) begin
            rec_next[i] = (st_reg == pusr_pkg::ST_BUILD) ? ch[i] : rec_reg[i];
        end
        len_next = (st_reg == pusr_pkg::ST_BUILD) ? n : len_reg;
        sum_next = (st_reg == pusr_pkg::ST_BUILD) ? s : sum_reg;
    end

    // ------------------------------------------------------------
    // sequence: measure, signal, build, send, command mode
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        idx_next = idx_reg;
        hold_low_next = hold_low_reg;
        cmd_next = cmd_reg;
        load_next = 1'b0;
        unique case (st_reg)
            pusr_pkg::ST_MEASURE: begin
                hold_low_next = 1'b1;                  // low while measuring
                cnt_next = cnt_reg + 32'h1;
                if (bus_addr_in != 8'h00) begin        // report suppressed
                    hold_low_next = 1'b0;
                    cmd_next = 1'b1;
                    st_next = pusr_pkg::ST_CMDMODE;
                end else if (cnt_reg >= 32'(RISE_CYCLES - 1)) begin // high within 100 ms
                    hold_low_next = 1'b0;
                    cnt_next = '0;
                    st_next = pusr_pkg::ST_SIGNAL;
                end
            end
            pusr_pkg::ST_SIGNAL: begin
                // line high; more measuring may go on here
                if (cnt_reg < 32'(SETTLE_CYCLES)) cnt_next = cnt_reg + 32'h1;
                if (done_s2_reg && cnt_reg >= 32'(SETTLE_CYCLES)) begin
                    st_next = pusr_pkg::ST_BUILD;
                end
            end
            pusr_pkg::ST_BUILD: begin
                idx_next = '0;
                load_next = 1'b1;
                st_next = pusr_pkg::ST_SEND;
            end
            pusr_pkg::ST_SEND: begin
                if (!txi.busy && !load_reg) begin
                    if (idx_reg == len_reg - 5'h1) begin
                        cmd_next = 1'b1;               // once per power cycle
                        st_next = pusr_pkg::ST_CMDMODE;
                    end else begin
                        idx_next = idx_reg + 5'h1;     // next character, line stays high
                        load_next = 1'b1;
                    end
                end
            end
            pusr_pkg::ST_CMDMODE: begin
                cmd_next = 1'b1;
            end
        endcase
    end

    // registers
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_reg <= pusr_pkg::ST_MEASURE;
            cnt_reg <= '0;
            idx_reg <= '0;
            len_reg <= '0;
            sum_reg <= '0;
            hold_low_reg <= 1'b1;
            cmd_reg <= 1'b0;
            load_reg <= 1'b0;
            for (int i = 0; i < `PUSR_REC_LEN; i++) rec_reg[i] <= 8'h00;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            idx_reg <= idx_next;
            len_reg <= len_next;
            sum_reg <= sum_next;
            hold_low_reg <= hold_low_next;
            cmd_reg <= cmd_next;
            load_reg <= load_next;
            for (int i = 0; i < `PUSR_REC_LEN; i++) rec_reg[i] <= rec_next[i];
        end
    end

    // ------------------------------------------------------------
    // pin drivers, registered
    // ------------------------------------------------------------
    logic line_reg, line_next;
    logic oe_n_reg, oe_n_next;

    // forced low while measuring, high once released, else the serialiser
    always_comb begin
        line_next = tx_line;
        oe_n_next = cmd_next;                          // released to command-mode logic
        if (cmd_next) begin
            line_next = 1'b1;
        end
        if (hold_low_next) begin
            line_next = 1'b0;                          // low while measuring
        end
    end

    // pin registers only, so every pin comes straight from a flip-flop
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            line_reg <= 1'b0;
            oe_n_reg <= 1'b0;
        end else begin
            line_reg <= line_next;
            oe_n_reg <= oe_n_next;
        end
    end
    assign line_out = line_reg;
    assign line_oe_n_out = oe_n_reg;
    assign cmd_mode_out = cmd_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence start_load_s;
        st_reg == pusr_pkg::ST_BUILD;
    endsequence

    rise_deadline_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        (st_reg == pusr_pkg::ST_MEASURE) |-> (cnt_reg < 32'(MAX_RISE)))
        else $error("line not raised in time");
    low_measure_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        (st_reg == pusr_pkg::ST_MEASURE && $past(st_reg) == pusr_pkg::ST_MEASURE
         && bus_addr_in == 8'h00) |-> !line_out)
        else $error("line high during measure");
    auto_start_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        start_load_s |=> ##2 (txi.data == `PUSR_CHR_TAB && !line_out))
        else $error("report did not start");
    suppress_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        (bus_addr_in != 8'h00 && st_reg == pusr_pkg::ST_MEASURE) |=> cmd_mode_out)
        else $error("report not suppressed");
    cmd_stay_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        cmd_mode_out |=> (cmd_mode_out && line_oe_n_out))
        else $error("left command mode");
    csum_form_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        (st_reg == pusr_pkg::ST_SEND) |->
        (rec_reg[len_reg - 5'h3] == ((sum_reg & 8'h3f) + 8'h20)))
        else $error("checksum character wrong");
    tail_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        (st_reg == pusr_pkg::ST_SEND) |->
        (rec_reg[len_reg - 5'h1] == 8'h0a && rec_reg[len_reg - 5'h2] == 8'h0d))
        else $error("terminator wrong");
    idle_high_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        (st_reg == pusr_pkg::ST_SEND && $past(st_reg) == pusr_pkg::ST_SEND
         && !txi.busy && !load_reg) |-> line_out)
        else $error("line low between characters");
    signal_high_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        (st_reg == pusr_pkg::ST_SIGNAL) |-> line_out)
        else $error("line low while signalling");
    settle_gate_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        (st_reg == pusr_pkg::ST_SIGNAL && cnt_reg < 32'(SETTLE_CYCLES))
        |=> (st_reg != pusr_pkg::ST_BUILD))
        else $error("report began before settling");
    // record contents are frozen once sending starts, so check them there
    first_char_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        (st_reg == pusr_pkg::ST_SEND) |-> (rec_reg[0] == `PUSR_CHR_TAB))
        else $error("first character not tab");
    type_char_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        (st_reg == pusr_pkg::ST_SEND) |-> (rec_reg[len_reg - 5'h4] == TYPE_CHAR))
        else $error("type character wrong");
endmodule : pusr_reporter

// file: pusr_logger_model.sv
// behavioural logger side: 8n1 receiver watching the sensor data line
`timescale 1ns/1ps
module pusr_logger_model #(
    parameter int BIT_CYCLES = 16
) (
    input  wire logic mclk_in,
    input  wire logic power_on_in,
    input  wire logic line_in,
    output logic      byte_valid_out,
    output logic [7:0] byte_out,
    output logic      frame_err_out,
    output int        first_start_cycles_out
);
    logic       armed_reg;
    logic       busy_reg;
    logic       first_reg;
    logic [7:0] shift_reg;
    int         cnt_reg;
    int         bit_reg;
    int         low_reg;

    // ----------------------------------------------------------------
    // receiver, cleared whenever the logger removes sensor power
    // ----------------------------------------------------------------
    always @(posedge mclk_in or negedge power_on_in) begin
        if (!power_on_in) begin
            armed_reg <= 1'b0;
            busy_reg <= 1'b0;
            first_reg <= 1'b1;
            low_reg <= 0;
            byte_valid_out <= 1'b0;
            frame_err_out <= 1'b0;
            first_start_cycles_out <= 0;
        end else begin
            byte_valid_out <= 1'b0;
            frame_err_out <= 1'b0;
            // low level before the line first rises is not framing
            if (armed_reg && first_reg) begin
                if (!line_in)
                    low_reg <= low_reg + 1;
                else if (low_reg != 0) begin
                    first_start_cycles_out <= low_reg;
                    first_reg <= 1'b0;
                end
            end
            if (!busy_reg) begin
                if (line_in)
                    armed_reg <= 1'b1;
                else if (armed_reg) begin
                    busy_reg <= 1'b1;
                    cnt_reg <= BIT_CYCLES / 2; // sample mid-bit
                    bit_reg <= 0;
                end
            end else if (cnt_reg > 1)
                cnt_reg <= cnt_reg - 1;
            else begin
                cnt_reg <= BIT_CYCLES;
                bit_reg <= bit_reg + 1;
                if (bit_reg == 0) begin
                    if (line_in)
                        busy_reg <= 1'b0; // glitch, not a start bit
                end else if (bit_reg <= 8)
                    shift_reg <= {line_in, shift_reg[7:1]}; // lsb first
                else begin
                    busy_reg <= 1'b0;
                    byte_out <= shift_reg;
                    byte_valid_out <= 1'b1;
                    frame_err_out <= !line_in; // stop must be high
                end
            end
        end
    end
endmodule : pusr_logger_model

// file: tb_pusr_reporter.sv
// self-checking bench for the power-up serial reporter
`timescale 1ns/1ps
`include "pusr_regs.svh"
module tb_pusr_reporter;
    localparam int         BITC   = 16;
    localparam int         RISE   = 5;
    localparam logic [7:0] TYPE_C = 8'h41; // arbitrary value
    logic        mclk_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic        meas_done_in = 1'b0;
    logic [16:0] cond = 17'h0;
    logic [10:0] temp = 11'h0;
    logic        neg = 1'b0;
    logic [7:0]  addr = 8'h0;
    logic        line_out;
    logic        line_oe_n_out;
    logic        cmd_mode_out;
    logic        line_wire;
    logic        rx_valid;
    logic [7:0]  rx_byte;
    logic        rx_ferr;
    int          first_start;
    logic [7:0]  rxq[$];
    logic [7:0]  exp_q[$];
    logic [31:0] seed = 32'd58985;
    int          n_errors = 0;
    int          check_count = 0;
    int          n_ferr = 0;
    int          cyc = 0;

    always #5 mclk_in = ~mclk_in;
    // released line is pulled up, so the idle level stays high
    assign line_wire = line_oe_n_out ? 1'b1 : line_out;

    pusr_reporter #(.BIT_CYCLES(BITC), .RISE_CYCLES(RISE), .SETTLE_CYCLES(20),
                    .TYPE_CHAR(TYPE_C)) i_pusr_reporter (
        .mclk_in(mclk_in), .reset_n_in(reset_n_in), .meas_done_in(meas_done_in),
        .conductivity_value_in(cond), .temp_tenths_in(temp), .temp_neg_in(neg),
        .bus_addr_in(addr), .line_out(line_out), .line_oe_n_out(line_oe_n_out),
        .cmd_mode_out(cmd_mode_out));

    pusr_logger_model #(.BIT_CYCLES(BITC)) i_pusr_logger_model (
        .mclk_in(mclk_in), .power_on_in(reset_n_in), .line_in(line_wire),
        .byte_valid_out(rx_valid), .byte_out(rx_byte), .frame_err_out(rx_ferr),
        .first_start_cycles_out(first_start));

    // ----------------------------------------------------------------
    // collection, timeout and reporting
    // ----------------------------------------------------------------
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (rx_valid) begin
            rxq.push_back(rx_byte);
            if (rx_ferr)
                n_ferr++;
        end
        if (cyc == 90000) begin
            n_errors++;
            give_verdict();
        end
    end

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check_byte

    task automatic check_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check_bit

    task automatic check_num(input int got, input int exp);
        check_count++;
        if (got != exp) begin
            n_errors++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check_num

    task automatic give_verdict();
        if (n_errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    // decimal text without leading zeros, zero itself as one digit
    function automatic void add_dec(input int v);
        int d[$];
        do begin
            d.push_front(v % 10);
            v = v / 10;
        end while (v > 0);
        foreach (d[i])
            exp_q.push_back(8'h30 + d[i][7:0]);
    endfunction : add_dec

    // expected record from the input values, checksum worked out here
    function automatic void make_expected();
        int sum;
        exp_q.delete();
        exp_q.push_back(`PUSR_CHR_TAB);
        add_dec(int'(cond));
        exp_q.push_back(`PUSR_CHR_SPACE);
        if (neg)
            exp_q.push_back(`PUSR_CHR_MINUS);
        add_dec(int'(temp) / 10);
        exp_q.push_back(`PUSR_CHR_DOT);
        add_dec(int'(temp) % 10);
        exp_q.push_back(`PUSR_CHR_CR);
        exp_q.push_back(TYPE_C);
        sum = 0;
        foreach (exp_q[i])
            sum += exp_q[i];
        exp_q.push_back(8'((sum % 64) + 32));
        exp_q.push_back(`PUSR_CHR_CR);
        exp_q.push_back(`PUSR_CHR_LF);
    endfunction : make_expected

    // one power cycle: power off, set the reading, power on, collect
    task automatic run_report(input int c, input int t, input logic n,
                              input logic [7:0] a, input int dly);
        int i;
        @(posedge mclk_in);
        #1;
        reset_n_in = 1'b0; // power removed
        meas_done_in = 1'b0;
        cond = c[16:0];
        temp = t[10:0];
        neg = n;
        addr = a;
        repeat (2) @(posedge mclk_in);
        #1;
        rxq.delete();
        n_ferr = 0;
        reset_n_in = 1'b1; // power applied starts the transfer
        @(posedge mclk_in);
        #1;
        check_bit(line_out, a != 8'h00); // low while measuring, high if suppressed
        check_bit(line_oe_n_out, a != 8'h00); // driven unless suppressed
        repeat (RISE + 4) @(posedge mclk_in);
        #1;
        check_bit(line_wire, 1'b1); // raised within the allowed time
        repeat (dly) @(posedge mclk_in);
        #1;
        meas_done_in = 1'b1;
        i = 0;
        while (cmd_mode_out !== 1'b1 && i < 8000) begin
            @(posedge mclk_in);
            #1;
            i++;
        end
        check_bit(cmd_mode_out, 1'b1);
        check_bit(line_oe_n_out, 1'b1);
        repeat (4 * BITC) @(posedge mclk_in);
        #1;
        check_bit(cmd_mode_out, 1'b1); // held until next power cycle
        if (a != 8'h00) begin
            check_num(rxq.size(), 0);
        end else begin
            make_expected();
            check_num(rxq.size(), exp_q.size());
            check_num(first_start, BITC); // one start bit length
            check_num(n_ferr, 0);
            for (i = 0; i < exp_q.size() && i < rxq.size(); i++)
                check_byte(rxq[i], exp_q[i]);
        end
    endtask : run_report

    // ----------------------------------------------------------------
    // main sequence: corner cases, then random readings
    // ----------------------------------------------------------------
    initial begin
        int k;
        int c;
        int t;
        repeat (2) @(posedge mclk_in);
        run_report(0, 0, 1'b0, 8'h00, 0); // done before settling ends
        run_report(99999, 9999, 1'b1, 8'h00, 60);
        run_report(5423, 223, 1'b0, 8'h00, 3);
        run_report(77, 5, 1'b1, 8'h01, 10); // non-zero address, no record
        run_report(123, 400, 1'b0, 8'hff, 0);
        for (k = 0; k < 8; k++) begin
            c = int'(xs() % 100000);
            t = int'(xs() % 10000);
            run_report(c, t, xs() % 2 == 1 && t != 0, 8'h00, int'(xs() % 40));
        end
        give_verdict();
    end
endmodule : tb_pusr_reporter
